// file: logic/sume_pkg.sv
// Notes on behaviour
// (RL1) while uart_reset_n_bit is zero the uart is held in reset, no activity
// (RL2) host clears reset bit before activation, sets it before uart use
// (RL3) synchronous select one gives sync mode, io data on bit zero of tx/rx
// (RL4) in sync mode card clock pin follows the manual card clock bit
// (RL5) host switches modes only after any transmission has finished
// (RL6) deselected card io goes high impedance; new sync card drives tx bit zero
// (RL7) aux manual clock bit drives no output
// (RL8) status bit always shows the aux interrupt input level
// (RL9) aux input change asserts interrupt unless aux interrupt disable bit set
// (RL10) asynchronous mode is reset default, selected when sync select is zero
// (RL11) async active card clock may be stopped high or low by stop bits
// (RL12) etu source is card clock, or doubled clock when double select set
// (RL13) divider field 000b forces undoubled card clock, double select ignored
// (RL14) etu source prescaled by 31 when prescaler select zero, else 32
// (RL15) prescaler drives 8-bit autoreload down counter; each reload is one etu
// (RL16) host sets etu to F over D card clock periods
// (RL17) host keeps card clock between 1MHz and 5MHz unless card allows more
// (RL18) host uses F 372 and D 1 during answer-to-reset and before pps
// (RL19) specific mode uses card F and D unless TA2 bit 5 says implicit
// (RL20) F 372 with D 1 or 2: prescale 31, divider 12 or 6, double off
// (RL21) one etu is prescale factor times reload value source clock periods
package sume_pkg;
  // register offsets on the byte-wide host port
  localparam logic [3:0] ADDR_CARD_SELECT = 4'h0;
  localparam logic [3:0] ADDR_CCR_A = 4'h1;
  localparam logic [3:0] ADDR_CCR_B = 4'h2;
  localparam logic [3:0] ADDR_CCR_AUX = 4'h3;
  localparam logic [3:0] ADDR_UART_CONTROL_REGISTER_TWO = 4'h4;
  localparam logic [3:0] ADDR_ETU_DIV = 4'h5;
  localparam logic [3:0] ADDR_UTR = 4'h6;
  localparam logic [3:0] ADDR_URR = 4'h7;
  localparam logic [3:0] ADDR_MSR = 4'h8;

  // card_select_register fields
  localparam int CSEL_LSB = 0;
  localparam int CSEL_RST_N_BIT = 3;
  // uart_control_register_two fields
  localparam int UART_CONTROL_REGISTER_TWO_PSC_BIT = 0;
  localparam int UART_CONTROL_REGISTER_TWO_AUX_INTERRUPT_DISABLE_BIT_BIT = 1;
  // mixed_status_register fields
  localparam int MSR_AUX_LEVEL_BIT = 0;
  localparam int MSR_AUX_IRQ_BIT = 1;

  localparam logic [1:0] SEL_CARD_A = 2'h0;
  localparam logic [1:0] SEL_CARD_B = 2'h1;
  localparam logic [1:0] SEL_CARD_AUX = 2'h2;
  localparam int NUM_IF = 3;

  localparam logic [2:0] DIV_FIELD_UNDOUBLED = 3'h0;
  localparam logic [4:0] PRESCALE_31_LAST = 5'h1e;
  localparam logic [4:0] PRESCALE_32_LAST = 5'h1f;

  // reset values
  localparam logic [7:0] RST_CARD_SELECT = 8'h00;
  localparam logic [7:0] RST_CCR = 8'h00;
  localparam logic [7:0] RST_UART_CONTROL_REGISTER_TWO = 8'h00;
  localparam logic [7:0] RST_ETU_DIV = 8'h0c;
  localparam logic [7:0] RST_UTR = 8'h01;

  // card clock control register layout, msb first
  typedef struct packed {
    logic sync_sel;
    logic stop_level;
    logic clock_stop;
    logic manual_clk;
    logic clk_double;
    logic [2:0] div_field;
  } sume_ccr_s;

  // one two-way pin at the design port
  typedef struct packed {
    logic o;
    logic oe_n;
  } sume_pin_s;
endpackage : sume_pkg

// file: logic/sume_etu_gen.sv
`timescale 1ns/100ps
`default_nettype none
module sume_etu_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic src_tick,
  input wire logic psc_32,
  input wire logic [7:0] reload,
  output logic etu_tick
);
  logic [4:0] pre_r;
  logic [7:0] cnt_r;
  logic pre_tick;
  logic run_q_r;
  logic [4:0] pre_last;

  assign pre_last = psc_32 ? sume_pkg::PRESCALE_32_LAST : sume_pkg::PRESCALE_31_LAST;
  assign pre_tick = run && src_tick && (pre_r == pre_last);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst || !run) begin
      pre_r <= 5'h00;
    end else if (src_tick) begin
      pre_r <= (pre_r == pre_last) ? 5'h00 : 5'(pre_r + 5'h01); // [RL14]
    end
  end

  always_ff @(posedge ref_clk) begin
    run_q_r <= rst ? 1'b0 : run;
  end

  // a reload of zero wraps through 256 prescaler periods
  always_ff @(posedge ref_clk) begin
    if (rst || !run || !run_q_r) begin
      cnt_r <= reload;
    end else if (pre_tick) begin
      cnt_r <= (cnt_r == 8'h01) ? reload : 8'(cnt_r - 8'h01); // [RL15]
    end
  end

  assign etu_tick = pre_tick && run_q_r && (cnt_r == 8'h01); // [RL15]

  ////////////////////////////////////////////////////////////////////////////
  logic [13:0] src_cnt_r;
  logic [13:0] want;
  always_ff @(posedge ref_clk) begin
    if (rst || !run || !run_q_r || etu_tick) begin
      src_cnt_r <= 14'h0000;
    end else if (src_tick) begin
      src_cnt_r <= 14'(src_cnt_r + 14'h0001);
    end
  end
  assign want = 14'({9'h000, pre_last} + 14'h0001) * 14'((reload == 8'h00) ? 14'h0100 : {6'h00, reload});

  // a change of reload or prescaler mid-interval makes one odd etu, so the check skips it
  logic first_seen_r;
  logic [7:0] reload_q_r;
  logic psc_q_r;
  logic cfg_change;
  assign cfg_change = (reload != reload_q_r) || (psc_32 != psc_q_r);
  always_ff @(posedge ref_clk) begin
    reload_q_r <= reload;
    psc_q_r <= psc_32;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || !run || cfg_change) begin
      first_seen_r <= 1'b0;
    end else if (etu_tick) begin
      first_seen_r <= 1'b1;
    end
  end

  chk_etu_length: assert property (@(posedge ref_clk) disable iff (rst) // [RL21]
    (etu_tick && first_seen_r && $stable(reload) && $stable(psc_32)) |-> (14'(src_cnt_r + 14'h0001) == want))
    else $error("etu length differs from prescale times reload");
  chk_prescale_gap: assert property (@(posedge ref_clk) disable iff (rst) // [RL14]
    pre_tick |-> (src_tick && pre_r == pre_last))
    else $error("prescaler output not on its last source tick");
  chk_etu_held: assert property (@(posedge ref_clk) disable iff (rst) // [RL1]
    !run |-> !etu_tick)
    else $error("etu tick while generator stopped");
endmodule : sume_etu_gen
`default_nettype wire

// file: logic/sume_top.sv
`timescale 1ns/100ps
`default_nettype none
module sume_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic card_clk_tick,
  input wire logic card_clk2_tick,
  input wire logic [1:0] card_clk_gen_level,
  output logic [1:0] card_clock_pin,
  input wire logic [2:0] card_io_pin_i,
  output logic [2:0] card_io_pin_o,
  output logic [2:0] card_io_pin_oe_n,
  input wire logic async_tx_bit,
  input wire logic async_tx_drive,
  input wire logic [7:0] async_rx_data,
  input wire logic aux_interrupt_input,
  output logic irq,
  output logic uart_active,
  output logic etu_tick
);
  logic [7:0] card_select_register_r;
  sume_pkg::sume_ccr_s ccr_r [sume_pkg::NUM_IF];
  logic [7:0] uart_control_register_two_r;
  logic [7:0] etu_divider_register_r;
  logic [7:0] uart_transmit_register_r;
  logic aux_q_r;
  logic aux_irq_r;
  logic [7:0] rdata_r;

  logic [1:0] card_sel;
  logic uart_reset_n_bit;
  logic psc_32;
  logic aux_interrupt_disable_bit;
  sume_pkg::sume_ccr_s cur_ccr;
  logic src_tick;
  logic msr_read;
  logic aux_change;

  assign card_sel = card_select_register_r[sume_pkg::CSEL_LSB +: 2];
  assign uart_reset_n_bit = card_select_register_r[sume_pkg::CSEL_RST_N_BIT];
  assign psc_32 = uart_control_register_two_r[sume_pkg::UART_CONTROL_REGISTER_TWO_PSC_BIT];
  assign aux_interrupt_disable_bit = uart_control_register_two_r[sume_pkg::UART_CONTROL_REGISTER_TWO_AUX_INTERRUPT_DISABLE_BIT_BIT];
  // select code three has no entry; fall back to reset settings rather than index past the array
  assign cur_ccr = (card_sel == 2'h3) ? sume_pkg::sume_ccr_s'(sume_pkg::RST_CCR) : ccr_r[card_sel];
  assign msr_read = reg_rd && (reg_addr == sume_pkg::ADDR_MSR);
  assign aux_change = aux_interrupt_input ^ aux_q_r;

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] off, input logic wr);
    wr_hit = wr && (a == off);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      card_select_register_r <= sume_pkg::RST_CARD_SELECT; // [RL1]
    end else if (wr_hit(reg_addr, sume_pkg::ADDR_CARD_SELECT, reg_wr)) begin
      card_select_register_r <= {4'h0, reg_wdata[3:0]};
    end
  end

  // the aux entry keeps its manual clock bit but nothing reads it onto a pin
  for (genvar i = 0; i < sume_pkg::NUM_IF; i++) begin : g_ccr
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        ccr_r[i] <= sume_pkg::RST_CCR; // [RL10]
      end else if (wr_hit(reg_addr, 4'(sume_pkg::ADDR_CCR_A + 4'(i)), reg_wr)) begin
        ccr_r[i] <= reg_wdata; // [RL7]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uart_control_register_two_r <= sume_pkg::RST_UART_CONTROL_REGISTER_TWO;
    end else if (wr_hit(reg_addr, sume_pkg::ADDR_UART_CONTROL_REGISTER_TWO, reg_wr)) begin
      uart_control_register_two_r <= {6'h00, reg_wdata[1:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      etu_divider_register_r <= sume_pkg::RST_ETU_DIV;
    end else if (wr_hit(reg_addr, sume_pkg::ADDR_ETU_DIV, reg_wr)) begin
      etu_divider_register_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uart_transmit_register_r <= sume_pkg::RST_UTR;
    end else if (wr_hit(reg_addr, sume_pkg::ADDR_UTR, reg_wr)) begin
      uart_transmit_register_r <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // aux interrupt handshake; a change in the clearing cycle still sets
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aux_q_r <= 1'b0;
      aux_irq_r <= 1'b0;
    end else begin
      aux_q_r <= aux_interrupt_input;
      if (aux_change && !aux_interrupt_disable_bit) begin
        aux_irq_r <= 1'b1; // [RL9]
      end else if (msr_read) begin
        aux_irq_r <= 1'b0;
      end
    end
  end
  assign irq = aux_irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // read path, data in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst || !reg_rd) begin
      rdata_r <= 8'h00;
    end else begin
      unique case (reg_addr)
        sume_pkg::ADDR_CARD_SELECT: rdata_r <= card_select_register_r;
        sume_pkg::ADDR_CCR_A: rdata_r <= ccr_r[0];
        sume_pkg::ADDR_CCR_B: rdata_r <= ccr_r[1];
        sume_pkg::ADDR_CCR_AUX: rdata_r <= ccr_r[2];
        sume_pkg::ADDR_UART_CONTROL_REGISTER_TWO: rdata_r <= uart_control_register_two_r;
        sume_pkg::ADDR_ETU_DIV: rdata_r <= etu_divider_register_r;
        sume_pkg::ADDR_UTR: rdata_r <= uart_transmit_register_r;
        sume_pkg::ADDR_URR: begin
          if (cur_ccr.sync_sel && card_sel != 2'h3) begin
            rdata_r <= {7'h00, card_io_pin_i[card_sel]}; // [RL3]
          end else begin
            rdata_r <= async_rx_data;
          end
        end
        sume_pkg::ADDR_MSR: rdata_r <= {6'h00, aux_irq_r, aux_interrupt_input}; // [RL8]
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // card io pins; only the selected interface drives, others float high
  for (genvar i = 0; i < sume_pkg::NUM_IF; i++) begin : g_io
    logic sel;
    assign sel = uart_reset_n_bit && (card_sel == 2'(i));
    always_ff @(posedge ref_clk) begin
      if (rst || !sel) begin
        card_io_pin_o[i] <= 1'b1; // [RL6]
        card_io_pin_oe_n[i] <= 1'b1; // [RL1]
      end else if (ccr_r[i].sync_sel) begin
        card_io_pin_o[i] <= uart_transmit_register_r[0]; // [RL3]
        card_io_pin_oe_n[i] <= 1'b0;
      end else begin
        card_io_pin_o[i] <= async_tx_bit; // [RL10]
        card_io_pin_oe_n[i] <= !async_tx_drive;
      end
    end
  end

  // card clock pins for the two interfaces that have one
  for (genvar i = 0; i < 2; i++) begin : g_clk
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        card_clock_pin[i] <= 1'b0;
      end else if (ccr_r[i].sync_sel) begin
        card_clock_pin[i] <= ccr_r[i].manual_clk; // [RL4]
      end else if (ccr_r[i].clock_stop) begin
        card_clock_pin[i] <= ccr_r[i].stop_level; // [RL11]
      end else begin
        card_clock_pin[i] <= card_clk_gen_level[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // etu source: doubled clock only exists when the divider field is nonzero
  always_comb begin
    if (cur_ccr.clk_double && cur_ccr.div_field != sume_pkg::DIV_FIELD_UNDOUBLED) begin
      src_tick = card_clk2_tick; // [RL12]
    end else begin
      src_tick = card_clk_tick; // [RL13]
    end
  end

  sume_etu_gen u_etu (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(uart_reset_n_bit), // [RL1]
    .src_tick(src_tick),
    .psc_32(psc_32),
    .reload(etu_divider_register_r),
    .etu_tick(etu_tick)
  );

  assign uart_active = uart_reset_n_bit;

  ////////////////////////////////////////////////////////////////////////////
  chk_reset_holds_io: assert property (@(posedge ref_clk) disable iff (rst) // [RL1]
    (!uart_reset_n_bit && $past(!uart_reset_n_bit)) |-> (card_io_pin_oe_n == 3'h7 && !etu_tick))
    else $error("uart activity while held in reset");
  chk_sync_clock_follow: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
    ccr_r[0].sync_sel |=> (card_clock_pin[0] == $past(ccr_r[0].manual_clk)))
    else $error("sync card clock does not follow manual bit");
  chk_stop_level: assert property (@(posedge ref_clk) disable iff (rst) // [RL11]
    (!ccr_r[1].sync_sel && ccr_r[1].clock_stop) |=> (card_clock_pin[1] == $past(ccr_r[1].stop_level)))
    else $error("stopped card clock not at stop level");
  chk_aux_level_read: assert property (@(posedge ref_clk) disable iff (rst) // [RL8]
    msr_read |=> (reg_rdata[sume_pkg::MSR_AUX_LEVEL_BIT] == $past(aux_interrupt_input)))
    else $error("status does not show aux input level");
  chk_aux_irq_set: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
    (aux_change && !aux_interrupt_disable_bit) |=> irq)
    else $error("aux change did not raise interrupt");
  chk_aux_irq_masked: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
    $rose(irq) |-> $past(aux_change && !aux_interrupt_disable_bit))
    else $error("interrupt raised without enabled aux change");
  chk_deselect_hiz: assert property (@(posedge ref_clk) disable iff (rst) // [RL6]
    (card_sel == sume_pkg::SEL_CARD_B) |=> (card_io_pin_oe_n[0] && card_io_pin_oe_n[2] && card_io_pin_o[0]))
    else $error("deselected card io still driven");
  chk_sync_tx_bit: assert property (@(posedge ref_clk) disable iff (rst) // [RL3]
    (uart_reset_n_bit && card_sel == sume_pkg::SEL_CARD_AUX && ccr_r[2].sync_sel)
      |=> (!card_io_pin_oe_n[2] && card_io_pin_o[2] == $past(uart_transmit_register_r[0])))
    else $error("sync io not carrying tx bit zero");
  chk_undoubled_src: assert property (@(posedge ref_clk) disable iff (rst) // [RL13]
    (cur_ccr.div_field == sume_pkg::DIV_FIELD_UNDOUBLED) |-> (src_tick == card_clk_tick))
    else $error("doubled clock used with divider field zero");
endmodule : sume_top
`default_nettype wire

// file: tb/sume_card_model.sv
`timescale 1ns/100ps
`default_nettype none
module sume_card_model (
  input wire logic [2:0] io_o,
  input wire logic [2:0] io_oe_n,
  input wire logic [2:0] card_oe,
  input wire logic [2:0] card_bit,
  output logic [2:0] io_i
);
  // wire level of each card io line, worked out from both parties' enables
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      // wired-and of both parties; a released line sits on its weak pull-up
      io_i[k] = (io_oe_n[k] ? 1'b1 : io_o[k]) & (card_oe[k] ? card_bit[k] : 1'b1);
    end
  end
endmodule : sume_card_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, got, exp); end end
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic card_clk_tick = 1'b0;
  logic card_clk2_tick = 1'b0;
  logic [1:0] card_clk_gen_level = 2'b00;
  logic [1:0] card_clock_pin;
  logic [2:0] io_i, io_o, io_oe_n;
  logic [2:0] card_oe = 3'b000;
  logic [2:0] card_bit = 3'b000;
  logic async_tx_bit = 1'b1;
  logic async_tx_drive = 1'b0;
  logic [7:0] async_rx_data = 8'h00;
  logic aux_in = 1'b0;
  logic irq, uart_active, etu_tick;
  logic rd_pend = 1'b0;
  logic [7:0] exp_v;
  logic [7:0] exp_q[$];
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int etu_count = 0;

  sume_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_clk_tick(card_clk_tick),
    .card_clk2_tick(card_clk2_tick), .card_clk_gen_level(card_clk_gen_level),
    .card_clock_pin(card_clock_pin), .card_io_pin_i(io_i), .card_io_pin_o(io_o),
    .card_io_pin_oe_n(io_oe_n), .async_tx_bit(async_tx_bit), .async_tx_drive(async_tx_drive),
    .async_rx_data(async_rx_data), .aux_interrupt_input(aux_in), .irq(irq),
    .uart_active(uart_active), .etu_tick(etu_tick));
  sume_card_model u_card (.io_o(io_o), .io_oe_n(io_oe_n), .card_oe(card_oe), .card_bit(card_bit),
    .io_i(io_i));

  always #20 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // card clock ticks: plain clock every 6 cycles, about 4.2 MHz, doubled clock every 3
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    card_clk_tick <= (cyc % 6 == 5);
    card_clk2_tick <= (cyc % 3 == 2);
    card_clk_gen_level <= {2{(cyc % 6) < 3}};
    if (etu_tick === 1'b1) begin
      etu_count <= etu_count + 1;
    end
    rd_pend <= reg_rd;
    if (cyc == 40000) begin
      fails++;
      wrap_up();
    end
  end

  // read data stand only in the cycle after the strobe
  always @(negedge ref_clk) begin
    if (rd_pend) begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata, exp_v)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : idle

  // cycles from one etu tick to the next, bounded wait
  task automatic etu_gap(output int p);
    int n, t0;
    n = 0;
    t0 = 0;
    for (int j = 0; j < 2; j++) begin
      t0 = cyc;
      do begin
        @(negedge ref_clk);
        n++;
      end while (etu_tick !== 1'b1 && n < 5000);
    end
    p = cyc - t0;
  endtask : etu_gap

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int p, rl, ps, snap;
    logic [7:0] ccrv[4] = '{8'h00, 8'h09, 8'h08, 8'h00};
    int srcs[4] = '{6, 3, 6, 6};
    void'($urandom(99720));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(sume_pkg::ADDR_CARD_SELECT, sume_pkg::RST_CARD_SELECT);
    rd(sume_pkg::ADDR_CCR_A, sume_pkg::RST_CCR);
    rd(sume_pkg::ADDR_ETU_DIV, sume_pkg::RST_ETU_DIV);
    rd(sume_pkg::ADDR_UTR, sume_pkg::RST_UTR);
    rd(4'h9, 8'h00);
    idle(400);
    `CHK(etu_count, 0)
    `CHK(uart_active, 1'b0)
    `CHK(io_oe_n, 3'b111)
    $display("test reset state done");
    // manual clock in sync mode, then stop high and low in async mode
    wr(sume_pkg::ADDR_CARD_SELECT, 8'h08);
    wr(sume_pkg::ADDR_CCR_A, 8'h90);
    idle(2);
    `CHK(uart_active, 1'b1)
    `CHK(card_clock_pin[0], 1'b1)
    wr(sume_pkg::ADDR_CCR_A, 8'h80);
    idle(3);
    `CHK(card_clock_pin[0], 1'b0)
    wr(sume_pkg::ADDR_CCR_A, 8'h60);
    idle(2);
    `CHK(card_clock_pin[0], 1'b1)
    idle(3);
    `CHK(card_clock_pin[0], 1'b1)
    wr(sume_pkg::ADDR_CCR_A, 8'h20);
    idle(3);
    `CHK(card_clock_pin[0], 1'b0)
    wr(sume_pkg::ADDR_CCR_B, 8'h60);
    idle(2);
    `CHK(card_clock_pin[1], 1'b1)
    $display("test card clock done");
    // sync data on bit zero, then hand-over to card B
    wr(sume_pkg::ADDR_CCR_A, 8'h80);
    wr(sume_pkg::ADDR_UTR, 8'h00);
    idle(2);
    `CHK(io_o[0], 1'b0)
    `CHK(io_oe_n[0], 1'b0)
    rd(sume_pkg::ADDR_URR, 8'h00);
    wr(sume_pkg::ADDR_UTR, 8'h01);
    idle(2);
    rd(sume_pkg::ADDR_URR, 8'h01);
    card_oe[0] <= 1'b1;
    card_bit[0] <= 1'b0;
    idle(1);
    rd(sume_pkg::ADDR_URR, 8'h00);
    card_oe[0] <= 1'b0;
    wr(sume_pkg::ADDR_CCR_B, 8'h80);
    wr(sume_pkg::ADDR_UTR, 8'h00);
    wr(sume_pkg::ADDR_CARD_SELECT, 8'h09);
    idle(2);
    `CHK(io_oe_n[0], 1'b1)
    `CHK(io_i[0], 1'b1)
    `CHK(io_o[1], 1'b0)
    `CHK(io_oe_n[1], 1'b0)
    // aux in sync mode: io carries tx bit zero, its manual clock reaches no pin
    wr(sume_pkg::ADDR_CCR_AUX, 8'h90);
    wr(sume_pkg::ADDR_UTR, 8'h01);
    wr(sume_pkg::ADDR_CARD_SELECT, 8'h0a);
    idle(2);
    `CHK(io_o[2], 1'b1)
    `CHK(io_oe_n[2], 1'b0)
    `CHK(io_oe_n[1], 1'b1)
    `CHK(card_clock_pin[1], 1'b0)
    rd(sume_pkg::ADDR_URR, 8'h01);
    // async mode: io from the uart core, rx register from the core byte
    wr(sume_pkg::ADDR_CARD_SELECT, 8'h08);
    wr(sume_pkg::ADDR_CCR_A, 8'h00);
    async_tx_drive <= 1'b1;
    async_tx_bit <= 1'b0;
    async_rx_data <= 8'($urandom);
    idle(2);
    `CHK(io_o[0], 1'b0)
    `CHK(io_oe_n[0], 1'b0)
    rd(sume_pkg::ADDR_URR, async_rx_data);
    $display("test io modes done");
    // aux interrupt with and without the disable bit
    wr(sume_pkg::ADDR_UART_CONTROL_REGISTER_TWO, 8'h00);
    rd(sume_pkg::ADDR_MSR, 8'h00);
    aux_in <= 1'b1;
    idle(2);
    `CHK(irq, 1'b1)
    rd(sume_pkg::ADDR_MSR, 8'h03);
    idle(1);
    `CHK(irq, 1'b0)
    wr(sume_pkg::ADDR_UART_CONTROL_REGISTER_TWO, 8'h02);
    aux_in <= 1'b0;
    idle(2);
    `CHK(irq, 1'b0)
    rd(sume_pkg::ADDR_MSR, 8'h00);
    $display("test aux interrupt done");
    // etu length over source, doubling, prescaler and reload; last entry is F 372 D 1
    for (int k = 0; k < 4; k++) begin
      rl = (k == 3) ? 12 : 1 + ($urandom % 3);
      ps = (k == 3) ? 0 : $urandom % 2;
      wr(sume_pkg::ADDR_UART_CONTROL_REGISTER_TWO, 8'(ps));
      wr(sume_pkg::ADDR_ETU_DIV, 8'(rl));
      wr(sume_pkg::ADDR_CCR_A, ccrv[k]);
      etu_gap(p);
      etu_gap(p);
      `CHK(p, (31 + ps) * rl * srcs[k])
    end
    $display("test etu generation done");
    wr(sume_pkg::ADDR_CARD_SELECT, 8'h00);
    idle(2);
    snap = etu_count;
    idle(1600);
    `CHK(etu_count, snap)
    `CHK(io_oe_n, 3'b111)
    $display("test uart reset done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
